//--- dmt_map.svh
// Register offsets, reset values, flag positions and tick counts of the timer unit.
`ifndef DMT_MAP_SVH
`define DMT_MAP_SVH

`define DMT_NUM_TIMERS 5
`define DMT_NUM_A 3
`define DMT_NUM_PINS 6

`define DMT_AUX_LOW 0
`define DMT_CORE_A 1
`define DMT_AUX_HIGH 2
`define DMT_AUX_B 3
`define DMT_CORE_B 4
`define DMT_CAP_PIN 5

`define DMT_REG_CTRL0 4'h0
`define DMT_REG_VAL0 4'h5
`define DMT_REG_B_CAPTURE_RELOAD_REG 4'ha
`define DMT_REG_FLAGS 4'hb
`define DMT_REG_FLAG_EN 4'hc
`define DMT_REG_STATUS 4'hd

`define DMT_CTRL_RST 16'h0000
`define DMT_VAL_RST 16'h0000
`define DMT_FLAGS_RST 8'h00
`define DMT_VAL_MAX 16'hffff
`define DMT_VAL_MIN 16'h0000

`define DMT_FLAG_CAP_LOW 5
`define DMT_FLAG_CAP_HIGH 6
`define DMT_FLAG_CAP_B 7

`define DMT_A_TICK_SHIFT 4'h2
`define DMT_B_TICK_SHIFT 4'h1
`define DMT_A_TICK_CYCLES 4
`define DMT_B_TICK_CYCLES 2

`endif

//--- dmt_pkg.sv
// Types shared by the timer unit files.
`default_nettype none
package dmt_pkg;
	typedef enum logic [1:0] {
		DMT_TIMER = 2'h0,
		DMT_COUNTER = 2'h1,
		DMT_GATED = 2'h2,
		DMT_ENCODER = 2'h3
	} dmt_mode_t;

	typedef enum logic [1:0] {
		DMT_NORMAL = 2'h0,
		DMT_CAPTURE = 2'h1,
		DMT_RELOAD = 2'h2,
		DMT_FUNC_RSVD = 2'h3
	} dmt_func_t;

	typedef struct packed {
		logic [1:0] trig;
		logic latch_clk;
		dmt_func_t func;
		logic opt;
		logic [1:0] edge_sel;
		logic ext_dir;
		logic down;
		logic run;
		dmt_mode_t mode;
		logic [2:0] presc;
	} dmt_ctrl_t;
endpackage
`default_nettype wire

//--- dmt_edge.sv
// Pin sampler giving edge pulses and quadrature steps at a sampling tick.
`default_nettype none
module dmt_edge (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Sampling tick and pins.
	input wire logic i_sample,
	input wire logic i_a,
	input wire logic i_b,
	// Events, valid only in a sampling cycle.
	output logic o_rise,
	output logic o_fall,
	output logic o_b_chg,
	output logic o_qstep,
	output logic o_qup
);
	logic prev_a;
	logic prev_b;

	// Pins high at reset give one spurious rise at the first tick.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else if (i_sample) begin
			prev_a <= i_a;
			prev_b <= i_b;
		end
	end

	assign o_rise = i_sample & i_a & ~prev_a;
	assign o_fall = i_sample & ~i_a & prev_a;
	assign o_b_chg = i_sample & (i_b ^ prev_b);
	assign o_qstep = i_sample & ((i_a ^ prev_a) | (i_b ^ prev_b));
	assign o_qup = i_a ^ prev_b;
endmodule
`default_nettype wire

//--- dmt_timer.sv
// One 16-bit up/down count register with load and wrap detection.
`default_nettype none
`include "dmt_map.svh"
module dmt_timer (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Count and load control.
	input wire logic i_step,
	input wire logic i_up,
	input wire logic i_load,
	input wire logic [15:0] i_load_val,
	// State.
	output logic [15:0] o_value,
	output logic o_wrap
);
	// Wrap ignores the load so that a reload fed by the wrap forms no loop.
	assign o_wrap = i_step & (i_up ? (o_value == `DMT_VAL_MAX) :
		(o_value == `DMT_VAL_MIN));

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_value <= `DMT_VAL_RST;
		end else if (i_load) begin
			o_value <= i_load_val;
		end else if (i_step) begin
			o_value <= i_up ? o_value + 16'h0001 : o_value - 16'h0001;
		end
	end
endmodule
`default_nettype wire

//--- dmt_top.sv
// Two-module timer unit: three timers in module A, two plus capture in B.
//
// The address map and the plain strobed port were chosen for this implementation.
`default_nettype none
`include "dmt_map.svh"
module dmt_top (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Register port.
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Timer pins.
	input wire logic [4:0] i_timer_input_pin,
	input wire logic [4:0] i_timer_direction_pin,
	input wire logic i_b_capture_pin,
	// Outputs.
	output logic o_core_a_toggle_pin,
	output logic o_core_b_toggle_pin,
	output logic o_core_b_wrap,
	output logic o_timer_request
);
	dmt_pkg::dmt_ctrl_t ctrl [`DMT_NUM_TIMERS];
	logic [15:0] value [`DMT_NUM_TIMERS];
	logic [15:0] load_val [`DMT_NUM_TIMERS];
	logic [15:0] hw_val [`DMT_NUM_TIMERS];
	logic [4:0] step;
	logic [4:0] up;
	logic [4:0] load;
	logic [4:0] hw_load;
	logic [4:0] sw_load;
	logic [4:0] wrap;
	logic [4:0] pin_ev;
	logic [4:0] cap_ev;
	logic [4:0] rel_ev;
	logic [5:0] rise;
	logic [5:0] fall;
	logic [5:0] b_chg;
	logic [5:0] qstep;
	logic [5:0] qup;
	logic [5:0] sample;
	logic [5:0] pin_a;
	logic [5:0] pin_b;
	logic [9:0] prescale_cnt;
	logic core_a_toggle_latch;
	logic core_b_toggle_latch;
	logic [15:0] b_capture_reload_reg;
	logic [7:0] flags;
	logic [7:0] flag_en;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic [15:0] rd_word;
	logic tick_a;
	logic tick_b;
	logic a_lat_rise;
	logic a_lat_fall;
	logic b_lat_rise;
	logic b_lat_fall;
	logic b_cap;
	logic b_cap_src_a;

	// True when the low n bits of the prescale counter are all ones.
	function automatic logic prescale_hit(input logic [9:0] c,
		input logic [3:0] n);
		logic [9:0] mask;
		mask = (10'h001 << n) - 10'h001;
		return &(c | ~mask);
	endfunction

	// Register index match, used by every write decode.
	function automatic logic reg_hit(input logic [3:0] a,
		input logic [3:0] r);
		return a == r;
	endfunction

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			prescale_cnt <= 10'h000;
		end else begin
			prescale_cnt <= prescale_cnt + 10'h001;
		end
	end

	// Pins of module A are only looked at on the slow tick, so no event
	// can make a module A timer step faster than its resolution.
	assign tick_a = prescale_hit(prescale_cnt, `DMT_A_TICK_SHIFT);
	assign tick_b = prescale_hit(prescale_cnt, `DMT_B_TICK_SHIFT);

	assign pin_a = {i_b_capture_pin, i_timer_input_pin};
	assign pin_b = {1'b0, i_timer_direction_pin};

	// Toggle latch transitions, seen in the same cycle as the wrap.
	assign a_lat_rise = wrap[`DMT_CORE_A] & ~core_a_toggle_latch;
	assign a_lat_fall = wrap[`DMT_CORE_A] & core_a_toggle_latch;
	assign b_lat_rise = wrap[`DMT_CORE_B] & ~core_b_toggle_latch;
	assign b_lat_fall = wrap[`DMT_CORE_B] & core_b_toggle_latch;

	genvar gi;
	generate
		for (gi = 0; gi < `DMT_NUM_PINS; gi++) begin : g_pin
			assign sample[gi] = (gi < `DMT_NUM_A || gi == `DMT_CAP_PIN) ?
				tick_a : tick_b;
			dmt_edge u_edge (
				.i_sys_clk(i_sys_clk),
				.i_rst(i_rst),
				.i_sample(sample[gi]),
				.i_a(pin_a[gi]),
				.i_b(pin_b[gi]),
				.o_rise(rise[gi]),
				.o_fall(fall[gi]),
				.o_b_chg(b_chg[gi]),
				.o_qstep(qstep[gi]),
				.o_qup(qup[gi])
			);
		end

		for (gi = 0; gi < `DMT_NUM_TIMERS; gi++) begin : g_tmr
			localparam bit IS_A = gi < `DMT_NUM_A;
			localparam bit IS_AUX_A = gi == `DMT_AUX_LOW ||
				gi == `DMT_AUX_HIGH;
			logic pre;
			logic gate;
			logic lat_ev;
			logic cnt_ev;
			logic raw;
			logic pin_dir;

			assign pre = prescale_hit(prescale_cnt, IS_A ?
				`DMT_A_TICK_SHIFT + 4'(ctrl[gi].presc) :
				`DMT_B_TICK_SHIFT + 4'(ctrl[gi].presc));
			assign gate = ctrl[gi].edge_sel[0] ? i_timer_input_pin[gi] :
				~i_timer_input_pin[gi];
			assign pin_ev[gi] = (ctrl[gi].edge_sel[0] & rise[gi]) |
				(ctrl[gi].edge_sel[1] & fall[gi]);
			// Chaining inside a module runs off the core toggle latch.
			if (IS_AUX_A) begin : g_lat_a
				assign lat_ev = (ctrl[gi].edge_sel[0] & a_lat_rise) |
					(ctrl[gi].edge_sel[1] & a_lat_fall);
			end else if (gi == `DMT_AUX_B) begin : g_lat_b
				assign lat_ev = (ctrl[gi].edge_sel[0] & b_lat_rise) |
					(ctrl[gi].edge_sel[1] & b_lat_fall);
			end else begin : g_lat_none
				assign lat_ev = 1'b0;
			end
			assign cnt_ev = ctrl[gi].latch_clk ? lat_ev : pin_ev[gi];

			always_comb begin
				case (ctrl[gi].mode)
				dmt_pkg::DMT_TIMER: raw = pre;
				dmt_pkg::DMT_GATED: raw = pre & gate;
				dmt_pkg::DMT_COUNTER: raw = cnt_ev;
				dmt_pkg::DMT_ENCODER: raw = IS_A & qstep[gi];
				default: raw = 1'b0;
				endcase
			end

			// An aux timer used as capture or reload register is stopped.
			assign step[gi] = ctrl[gi].run & raw & ~(IS_AUX_A &&
				ctrl[gi].func != dmt_pkg::DMT_NORMAL);
			assign pin_dir = ctrl[gi].ext_dir & i_timer_direction_pin[gi];
			assign up[gi] = (IS_A && ctrl[gi].mode == dmt_pkg::DMT_ENCODER) ?
				qup[gi] : ~(ctrl[gi].down ^ pin_dir);

			assign cap_ev[gi] = IS_AUX_A &&
				ctrl[gi].func == dmt_pkg::DMT_CAPTURE && pin_ev[gi];
			always_comb begin
				case (ctrl[gi].trig)
				2'h0: rel_ev[gi] = pin_ev[gi];
				2'h1: rel_ev[gi] = a_lat_rise;
				2'h2: rel_ev[gi] = a_lat_fall;
				default: rel_ev[gi] = a_lat_rise | a_lat_fall;
				endcase
				if (!IS_AUX_A || ctrl[gi].func != dmt_pkg::DMT_RELOAD) begin
					rel_ev[gi] = 1'b0;
				end
			end

			// Software writes win over hardware loads in the same cycle.
			assign sw_load[gi] = i_wr &
				reg_hit(i_addr, `DMT_REG_VAL0 + 4'(gi));
			assign load[gi] = sw_load[gi] | hw_load[gi];
			assign load_val[gi] = sw_load[gi] ? i_wdata : hw_val[gi];

			always_ff @(posedge i_sys_clk) begin
				if (i_rst) begin
					ctrl[gi] <= dmt_pkg::dmt_ctrl_t'(`DMT_CTRL_RST);
				end else if (i_wr &&
					reg_hit(i_addr, `DMT_REG_CTRL0 + 4'(gi))) begin
					ctrl[gi] <= dmt_pkg::dmt_ctrl_t'(i_wdata);
				end
			end

			dmt_timer u_tmr (
				.i_sys_clk(i_sys_clk),
				.i_rst(i_rst),
				.i_step(step[gi]),
				.i_up(up[gi]),
				.i_load(load[gi]),
				.i_load_val(load_val[gi]),
				.o_value(value[gi]),
				.o_wrap(wrap[gi])
			);
		end
	endgenerate

	// Hardware loads. Two aux timers reloading on opposite latch edges
	// alternate the low and high times of a PWM wave with no software.
	assign hw_load[`DMT_AUX_LOW] = cap_ev[`DMT_AUX_LOW];
	assign hw_val[`DMT_AUX_LOW] = value[`DMT_CORE_A];
	assign hw_load[`DMT_AUX_HIGH] = cap_ev[`DMT_AUX_HIGH];
	assign hw_val[`DMT_AUX_HIGH] = value[`DMT_CORE_A];
	assign hw_load[`DMT_CORE_A] = rel_ev[`DMT_AUX_LOW] |
		rel_ev[`DMT_AUX_HIGH];
	assign hw_val[`DMT_CORE_A] = rel_ev[`DMT_AUX_HIGH] ?
		value[`DMT_AUX_HIGH] : value[`DMT_AUX_LOW];
	assign hw_load[`DMT_AUX_B] = b_cap & ctrl[`DMT_AUX_B].opt;
	assign hw_val[`DMT_AUX_B] = `DMT_VAL_RST;
	assign hw_load[`DMT_CORE_B] = wrap[`DMT_CORE_B] &
		ctrl[`DMT_CORE_B].func[0];
	assign hw_val[`DMT_CORE_B] = b_capture_reload_reg;

	// Capture trigger of module B, from its own pin or the core A pins.
	assign b_cap_src_a = (ctrl[`DMT_AUX_B].edge_sel[0] & rise[`DMT_CORE_A]) |
		(ctrl[`DMT_AUX_B].edge_sel[1] & fall[`DMT_CORE_A]);
	always_comb begin
		case (ctrl[`DMT_AUX_B].trig)
		2'h0: b_cap = (ctrl[`DMT_AUX_B].edge_sel[0] & rise[`DMT_CAP_PIN]) |
			(ctrl[`DMT_AUX_B].edge_sel[1] & fall[`DMT_CAP_PIN]);
		2'h1: b_cap = b_cap_src_a;
		2'h2: b_cap = b_chg[`DMT_CORE_A];
		default: b_cap = b_cap_src_a | b_chg[`DMT_CORE_A];
		endcase
	end

	// A capture coinciding with a software write keeps the captured value.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			b_capture_reload_reg <= `DMT_VAL_RST;
		end else if (b_cap) begin
			b_capture_reload_reg <= value[`DMT_AUX_B];
		end else if (i_wr && reg_hit(i_addr, `DMT_REG_B_CAPTURE_RELOAD_REG)) begin
			b_capture_reload_reg <= i_wdata;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			core_a_toggle_latch <= 1'b0;
			core_b_toggle_latch <= 1'b0;
		end else begin
			core_a_toggle_latch <= core_a_toggle_latch ^
				wrap[`DMT_CORE_A];
			core_b_toggle_latch <= core_b_toggle_latch ^
				wrap[`DMT_CORE_B];
		end
	end

	// Request flags: a set in the same cycle as its clear survives.
	assign flag_set = {b_cap, cap_ev[`DMT_AUX_HIGH], cap_ev[`DMT_AUX_LOW],
		wrap};
	assign flag_clr = (i_wr && reg_hit(i_addr, `DMT_REG_FLAGS)) ?
		i_wdata[7:0] : `DMT_FLAGS_RST;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			flags <= `DMT_FLAGS_RST;
			flag_en <= `DMT_FLAGS_RST;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
			if (i_wr && reg_hit(i_addr, `DMT_REG_FLAG_EN)) begin
				flag_en <= i_wdata[7:0];
			end
		end
	end

	always_comb begin
		rd_word = 16'h0000;
		for (int k = 0; k < `DMT_NUM_TIMERS; k++) begin
			if (i_addr == `DMT_REG_CTRL0 + 4'(k)) begin
				rd_word = 16'(ctrl[k]);
			end
			if (i_addr == `DMT_REG_VAL0 + 4'(k)) begin
				rd_word = value[k];
			end
		end
		case (i_addr)
		`DMT_REG_B_CAPTURE_RELOAD_REG: rd_word = b_capture_reload_reg;
		`DMT_REG_FLAGS: rd_word = {8'h00, flags};
		`DMT_REG_FLAG_EN: rd_word = {8'h00, flag_en};
		`DMT_REG_STATUS: rd_word = {14'h0000, core_b_toggle_latch,
			core_a_toggle_latch};
		default: ;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
			o_core_a_toggle_pin <= 1'b0;
			o_core_b_toggle_pin <= 1'b0;
			o_core_b_wrap <= 1'b0;
			o_timer_request <= 1'b0;
		end else begin
			o_rdata <= i_rd ? rd_word : 16'h0000;
			o_core_a_toggle_pin <= ctrl[`DMT_CORE_A].opt &
				core_a_toggle_latch;
			o_core_b_toggle_pin <= ctrl[`DMT_CORE_B].opt &
				core_b_toggle_latch;
			o_core_b_wrap <= wrap[`DMT_CORE_B];
			o_timer_request <= |(flags & flag_en);
		end
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	AST_A_RATE: assert property (
		step[`DMT_CORE_A] |=> !step[`DMT_CORE_A] [*3])
		else $error("core A stepped faster than every 4 cycles");
	AST_B_RATE: assert property (
		step[`DMT_CORE_B] |=> !step[`DMT_CORE_B])
		else $error("core B stepped faster than every 2 cycles");
	AST_LATCH_A: assert property (
		wrap[`DMT_CORE_A] |=> core_a_toggle_latch !=
		$past(core_a_toggle_latch))
		else $error("core A latch did not toggle on wrap");
	AST_AUX_STOP: assert property (
		ctrl[`DMT_AUX_LOW].func != dmt_pkg::DMT_NORMAL &&
		!sw_load[`DMT_AUX_LOW] && !cap_ev[`DMT_AUX_LOW] |=>
		$stable(value[`DMT_AUX_LOW]))
		else $error("aux low counted while used as register");
	AST_CAPTURE: assert property (
		cap_ev[`DMT_AUX_HIGH] && !sw_load[`DMT_AUX_HIGH] |=>
		value[`DMT_AUX_HIGH] == $past(value[`DMT_CORE_A]))
		else $error("aux high did not capture core A");
	AST_RELOAD: assert property (
		hw_load[`DMT_CORE_A] && !sw_load[`DMT_CORE_A] |=>
		value[`DMT_CORE_A] == $past(hw_val[`DMT_CORE_A]))
		else $error("core A reload value wrong");
	AST_B_RELOAD: assert property (
		wrap[`DMT_CORE_B] && ctrl[`DMT_CORE_B].func[0] &&
		!sw_load[`DMT_CORE_B] |=>
		value[`DMT_CORE_B] == $past(b_capture_reload_reg) && o_core_b_wrap)
		else $error("core B wrap did not reload or signal");
	AST_B_CAPTURE_RELOAD_REG: assert property (
		b_cap |=> b_capture_reload_reg == $past(value[`DMT_AUX_B]))
		else $error("capture register missed aux B value");
	AST_GATE: assert property (
		ctrl[`DMT_CORE_A].mode == dmt_pkg::DMT_GATED &&
		(ctrl[`DMT_CORE_A].edge_sel[0] != i_timer_input_pin[`DMT_CORE_A])
		|-> !step[`DMT_CORE_A])
		else $error("gated timer counted with gate closed");
	AST_UP: assert property (
		step[`DMT_CORE_A] && up[`DMT_CORE_A] && !load[`DMT_CORE_A] |=>
		value[`DMT_CORE_A] == 16'($past(value[`DMT_CORE_A]) + 16'h0001))
		else $error("core A did not count up");
	AST_FLAG: assert property (
		wrap[`DMT_CORE_A] |=> flags[`DMT_CORE_A] [*2] or
		(flags[`DMT_CORE_A] ##1 $past(flag_clr[`DMT_CORE_A])))
		else $error("wrap flag not set");

	COV_PWM: cover property (rel_ev[`DMT_AUX_LOW] ##[1:1000]
		rel_ev[`DMT_AUX_HIGH]);
	COV_B_CAP_CLEAR: cover property (b_cap && ctrl[`DMT_AUX_B].opt);
	COV_ENCODER: cover property (ctrl[`DMT_CORE_A].mode ==
		dmt_pkg::DMT_ENCODER && step[`DMT_CORE_A] && !up[`DMT_CORE_A]);
endmodule
`default_nettype wire

//--- dmt_pin_model.sv
// Pin source model: pulse, gate and quadrature encoder stimulus.
`default_nettype none
module dmt_pin_model (
	// Clock.
	input wire logic i_sys_clk,
	// Pins toward the timer unit.
	output logic [4:0] o_in,
	output logic [4:0] o_dir,
	output logic o_cap
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] q;
	initial begin
		o_in = 5'h00;
		o_dir = 5'h00;
		o_cap = 1'b0;
		q = 2'h0;
	end
	// Each level lasts 8 cycles so that two module A sampling ticks see it.
	task automatic hold();
		repeat (8) @(posedge i_sys_clk);
	endtask
	// Index 5 stands for the capture pin.
	task automatic set_in(input int idx, input logic v);
		@(posedge i_sys_clk);
		if (idx == 5) begin
			o_cap <= v;
		end else begin
			o_in[idx] <= v;
		end
	endtask
	task automatic set_dir(input int idx, input logic v);
		@(posedge i_sys_clk);
		o_dir[idx] <= v;
	endtask
	task automatic pulse(input int idx);
		set_in(idx, 1'b1);
		hold();
		set_in(idx, 1'b0);
		hold();
	endtask
	// Signal A leads B when moving forward; one step changes one line.
	task automatic quad(input int n, input logic up);
		repeat (4 * n) begin
			q = up ? q + 2'h1 : q - 2'h1;
			@(posedge i_sys_clk);
			o_in[1] <= q[1] ^ q[0];
			o_dir[1] <= q[1];
			hold();
		end
	endtask
endmodule
`default_nettype wire

//--- test_dmt_top.sv
// Self-checking bench for the two-module timer unit.
`default_nettype none
`include "dmt_map.svh"
`define CHK(nm, exp, got) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("Error %s expected %h seen %h", nm, exp, got); \
	end \
end
module test_dmt_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_sys_clk;
	logic i_rst;
	logic [3:0] i_addr;
	logic [15:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [15:0] o_rdata;
	logic [4:0] pin_in;
	logic [4:0] pin_dir;
	logic pin_cap;
	logic o_core_a_toggle_pin;
	logic o_core_b_toggle_pin;
	logic o_core_b_wrap;
	logic o_timer_request;
	int miscompares = 0;
	int n_tests = 0;
	int wraps_b = 0;

	dmt_top uut (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_timer_input_pin(pin_in),
		.i_timer_direction_pin(pin_dir),
		.i_b_capture_pin(pin_cap),
		.o_core_a_toggle_pin(o_core_a_toggle_pin),
		.o_core_b_toggle_pin(o_core_b_toggle_pin),
		.o_core_b_wrap(o_core_b_wrap),
		.o_timer_request(o_timer_request)
	);
	dmt_pin_model pins (
		.i_sys_clk(i_sys_clk),
		.o_in(pin_in),
		.o_dir(pin_dir),
		.o_cap(pin_cap)
	);

	initial begin
		i_sys_clk = 1'b0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		if (o_core_b_wrap === 1'b1) begin
			wraps_b <= wraps_b + 1;
		end
	end

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic chk_reg(input logic [3:0] a, input logic [15:0] e,
			input string nm);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		`CHK(nm, e, o_rdata)
	endtask
	// Ticks are periodic, so a run window of n cycles, n a multiple of the tick period,
	// holds a fixed count of ticks whatever the prescaler phase is.
	task automatic run_for(input logic [3:0] a, input logic [15:0] c,
			input int n);
		wr_reg(a, c | 16'h0020);
		repeat (n - 2) @(posedge i_sys_clk);
		wr_reg(a, c);
	endtask

	initial begin
		repeat (20000) @(posedge i_sys_clk);
		miscompares++;
		complete_run();
	end

	initial begin
		i_rst = 1'b1;
		i_addr = 4'h0;
		i_wdata = 16'h0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (5) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		chk_reg(`DMT_REG_CTRL0, 16'h0000, "ctrl0 reset");
		chk_reg(`DMT_REG_FLAGS, 16'h0000, "flags reset");
		wr_reg(4'he, 16'hffff);
		chk_reg(4'he, 16'h0000, "unmapped");
		wr_reg(`DMT_REG_STATUS, 16'hffff);
		chk_reg(`DMT_REG_STATUS, 16'h0000, "status ro");
		@(posedge i_sys_clk);
		#1;
		`CHK("rdata idle", 16'h0000, o_rdata)
		for (int i = 0; i < 5; i++) begin
			run_for(4'(i), 16'h0000, 40);
			chk_reg(4'h5 + 4'(i), i < 3 ? 16'h000a : 16'h0014, "rate");
		end
		wr_reg(4'h6, 16'h0000);
		run_for(4'h1, 16'h0001, 80);
		chk_reg(4'h6, 16'h000a, "prescaler");
		wr_reg(4'h6, 16'h0000);
		run_for(4'h1, 16'h0440, 4);
		chk_reg(4'h6, 16'hffff, "down wrap");
		chk_reg(`DMT_REG_FLAGS, 16'h0002, "wrap flag");
		chk_reg(`DMT_REG_STATUS, 16'h0001, "latch a");
		`CHK("toggle a", 1'b1, o_core_a_toggle_pin)
		wr_reg(`DMT_REG_FLAGS, 16'h00ff);
		pins.set_dir(1, 1'b1);
		wr_reg(4'h6, 16'h0010);
		run_for(4'h1, 16'h0080, 16);
		chk_reg(4'h6, 16'h000c, "dir pin");
		pins.set_dir(1, 1'b0);
		wr_reg(4'h1, 16'h0128);
		wr_reg(4'h6, 16'h0000);
		repeat (3) pins.pulse(1);
		chk_reg(4'h6, 16'h0003, "counter");
		wr_reg(4'h1, 16'h0038);
		wr_reg(4'h6, 16'h0000);
		pins.quad(2, 1'b1);
		chk_reg(4'h6, 16'h0008, "encoder up");
		pins.quad(1, 1'b0);
		chk_reg(4'h6, 16'h0004, "encoder down");
		wr_reg(4'h6, 16'h0000);
		wr_reg(4'h1, 16'h0130);
		// The gate stays open for exactly 40 cycles, so 10 ticks.
		pins.set_in(1, 1'b1);
		repeat (39) @(posedge i_sys_clk);
		pins.set_in(1, 1'b0);
		repeat (8) @(posedge i_sys_clk);
		chk_reg(4'h6, 16'h000a, "gated");
		wr_reg(4'h1, 16'h0000);
		wr_reg(4'h6, 16'h1234);
		wr_reg(4'h5, 16'h0007);
		wr_reg(4'h0, 16'h0920);
		repeat (40) @(posedge i_sys_clk);
		chk_reg(4'h5, 16'h0007, "aux halted");
		pins.pulse(0);
		chk_reg(4'h5, 16'h1234, "capture a");
		wr_reg(4'h7, 16'h5555);
		wr_reg(4'h2, 16'h1100);
		pins.pulse(2);
		chk_reg(4'h6, 16'h5555, "reload a");
		wr_reg(4'h8, 16'h0abc);
		wr_reg(4'h3, 16'h0500);
		pins.pulse(5);
		chk_reg(`DMT_REG_B_CAPTURE_RELOAD_REG, 16'h0abc, "capture b");
		chk_reg(4'h8, 16'h0000, "clear b");
		wr_reg(4'h8, 16'h0321);
		wr_reg(4'h3, 16'h4100);
		pins.pulse(1);
		chk_reg(`DMT_REG_B_CAPTURE_RELOAD_REG, 16'h0321, "capture src");
		wr_reg(4'h9, 16'hffff);
		run_for(4'h4, 16'h0c00, 2);
		chk_reg(4'h9, 16'h0321, "reload b");
		`CHK("wrap pulses", 1, wraps_b)
		`CHK("toggle b", 1'b1, o_core_b_toggle_pin)
		wr_reg(4'h7, 16'h0000);
		wr_reg(4'h2, 16'h2328);
		wr_reg(4'h6, 16'hffff);
		run_for(4'h1, 16'h0000, 4);
		repeat (8) @(posedge i_sys_clk);
		chk_reg(4'h7, 16'h0001, "latch clock");
		chk_reg(`DMT_REG_FLAGS, 16'h00b2, "flags");
		wr_reg(`DMT_REG_FLAG_EN, 16'h0010);
		repeat (2) @(posedge i_sys_clk);
		#1;
		`CHK("request", 1'b1, o_timer_request)
		wr_reg(`DMT_REG_FLAGS, 16'h00ff);
		repeat (2) @(posedge i_sys_clk);
		#1;
		`CHK("request off", 1'b0, o_timer_request)
		// Starting with the latch low, it stays high two ticks, low four.
		wr_reg(4'h5, 16'hfffe);
		wr_reg(4'h7, 16'hfffc);
		wr_reg(4'h0, 16'h5000);
		wr_reg(4'h2, 16'h9000);
		wr_reg(4'h6, 16'hffff);
		run_for(4'h1, 16'h0000, 28);
		chk_reg(4'h6, 16'hfffe, "pwm value");
		chk_reg(`DMT_REG_STATUS, 16'h0003, "pwm latch");
		wr_reg(4'h2, 16'h0900);
		pins.pulse(2);
		chk_reg(4'h7, 16'hfffe, "capture high");
		wr_reg(4'h4, 16'h0128);
		wr_reg(4'h9, 16'h0000);
		repeat (2) pins.pulse(4);
		chk_reg(4'h9, 16'h0002, "counter b");
		wr_reg(4'h8, 16'h0077);
		wr_reg(4'h3, 16'h8000);
		pins.set_dir(1, 1'b1);
		repeat (8) @(posedge i_sys_clk);
		chk_reg(`DMT_REG_B_CAPTURE_RELOAD_REG, 16'h0077, "capture dir");
		complete_run();
	end
endmodule
`default_nettype wire
